// *** hdl/csr_device.sv ***
`timescale 1ns/10ps
module csr_device
   import csr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic soft_reset,
   input wire logic strap_alt,
   // host side
   csr_if.dev bus,
   // clock gating
   input wire logic [csr_pkg::NUM_CLKS-1:0] clk_in,
   output logic [csr_pkg::NUM_CLKS-1:0] clk_out,
   output logic [csr_pkg::NUM_CLKS-1:0] clk_oe,
   // unit status
   output logic [csr_pkg::NUM_UNITS-1:0] unit_on,
   output logic [csr_pkg::NUM_UNITS-1:0] unit_valid,
   output logic irq_edge_high
);
   import csr_pkg::*;
   logic [7:0] index_reg, ldn_reg, pwr_reg, cfg_lo_reg, cfg_hi_reg, mask_reg;
   logic [7:0] t1_reg, t2_reg, t3_reg;
   logic strap_seen_reg;
   // committed port; low byte stays staged until the high byte lands
   logic [15:0] port_reg;
   logic [7:0] bank_rd [NUM_UNITS];
   logic [15:0] pbase [NUM_UNITS];
   logic [NUM_UNITS-1:0] act;
   wire [15:0] cfg_port = port_reg;
   wire [7:0] lo_dflt = strap_alt ? RST_CFG_LO_S1 : RST_CFG_LO_S0;
   wire hit_index = bus.addr == cfg_port;
   wire hit_data = bus.addr == cfg_port + 16'h0001;
   wire idx_wr = bus.wr && hit_index && bus.cfg_mode;
   wire dat_wr = bus.wr && hit_data && bus.cfg_mode;
   // soft reset wins over a data write in the same cycle
   wire dat_live = dat_wr && !soft_reset;
   wire in_bank = index_reg >= IDX_BANK_LO;
   wire ldn_ok = ldn_reg < NUM_UNITS;
   wire [3:0] sel = ldn_reg[3:0];
   wire pwr_wr = dat_live && index_reg == IDX_POWER;
   // chip-level write strobes
   wire wr_ldn = dat_live && index_reg == IDX_LDN;
   wire wr_cfg_lo = dat_live && index_reg == IDX_CFG_LO;
   wire wr_cfg_hi = dat_live && index_reg == IDX_CFG_HI;
   wire wr_mask = dat_live && index_reg == IDX_CLK_MASK;
   wire wr_t1 = dat_live && index_reg == IDX_TEST1;
   wire wr_t2 = dat_live && index_reg == IDX_TEST2;
   wire wr_t3 = dat_live && index_reg == IDX_TEST3;
   // power bit position for each unit, none where absent
   function automatic int pwr_bit(input int u);
      case (u)
         0: pwr_bit = 0;
         1: pwr_bit = 1;
         2: pwr_bit = 2;
         3: pwr_bit = 3;
         4: pwr_bit = 4;
         5: pwr_bit = 5;
         default: pwr_bit = -1;
      endcase
   endfunction : pwr_bit
   // permitted base range per unit
   function automatic logic base_ok(input int u, input logic [15:0] b);
      case (u)
         0, 1, 2, 4, 5: base_ok = b >= 16'h0100 && b <= 16'h0FF8 && b[2:0] == 3'h0;
         3: base_ok = b >= 16'h0100 && b <= 16'h0FFC && b[1:0] == 2'h0;
         8: base_ok = b <= 16'h0FFF;
         default: base_ok = 1'b1;
      endcase
   endfunction : base_ok
   // activation write that also moves a power bit, units 0 to 5 only
   wire act_hit = in_bank && ldn_ok && index_reg == IDX_ACT;
   wire act_link = dat_live && act_hit && pwr_bit(int'(sel)) >= 0;
   // index and unit number; soft reset clears both, port address stays
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         index_reg <= RST_ZERO;
         ldn_reg <= RST_ZERO;
      end else if (ce) begin
         if (soft_reset) begin
            index_reg <= RST_ZERO;
            ldn_reg <= RST_ZERO;
         end else begin
            if (idx_wr) index_reg <= bus.wdata;
            if (wr_ldn) ldn_reg <= bus.wdata;
         end
      end
   end
   // moving on the low byte alone would strand a host between its two writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_hi_reg <= RST_CFG_HI;
         cfg_lo_reg <= RST_CFG_LO_S0;
         port_reg <= {RST_CFG_HI, RST_CFG_LO_S0};
         strap_seen_reg <= 1'b0;
      end else if (ce) begin
         // strap caught on first enabled edge after release
         if (!strap_seen_reg) begin
            strap_seen_reg <= 1'b1;
            cfg_lo_reg <= lo_dflt;
            port_reg <= {RST_CFG_HI, lo_dflt};
         end else if (wr_cfg_lo) begin
            cfg_lo_reg <= bus.wdata;
         end else if (wr_cfg_hi) begin
            cfg_hi_reg <= bus.wdata;
            port_reg <= {bus.wdata, cfg_lo_reg};
         end
      end
   end
   // clock mask and test locations
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_reg <= RST_ZERO;
         t1_reg <= RST_ZERO;
         t2_reg <= RST_ZERO;
         t3_reg <= RST_ZERO;
      end else if (ce) begin
         if (wr_mask) mask_reg <= bus.wdata & CLK_MASK_BITS;
         if (wr_t1) t1_reg <= bus.wdata;
         if (wr_t2) t2_reg <= bus.wdata;
         if (wr_t3) t3_reg <= bus.wdata;
      end
   end
   // power bits 0 to 5 follow activation; bit 7 is reserved
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_reg <= RST_ZERO;
      end else if (ce) begin
         if (pwr_wr) pwr_reg <= bus.wdata & 8'h7F;
         else if (act_link) pwr_reg[pwr_bit(int'(sel))] <= bus.wdata[0];
      end
   end
   genvar g;
   generate
      for (g = 0; g < NUM_UNITS; g++) begin : g_unit
         localparam int PB = pwr_bit(g);
         wire bank_wr = dat_wr && in_bank && ldn_ok && sel == 4'(g) && !soft_reset;
         wire p_set = pwr_wr && PB >= 0;
         wire p_val = (PB >= 0) ? bus.wdata[(PB >= 0) ? PB : 0] : 1'b0;
         csr_unit_bank #(.UNIT(4'(g))) u_bank (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .wr_en(bank_wr),
            .idx(index_reg),
            .wdata(bus.wdata),
            .pwr_set(p_set),
            .pwr_val(p_val),
            .rdata(bank_rd[g]),
            .active(act[g]),
            .pbase(pbase[g]),
            .sbase(),
            .irq_a(),
            .irq_b(),
            .dma()
         );
         assign unit_on[g] = act[g] || (PB >= 0 && pwr_reg[(PB >= 0) ? PB : 0]);
         assign unit_valid[g] = unit_on[g] && base_ok(g, pbase[g]);
      end
   endgenerate
   // chip-level read mux
   logic [7:0] chip_rd;
   always_comb begin
      case (index_reg)
         IDX_LDN: chip_rd = ldn_reg;
         IDX_POWER: chip_rd = pwr_reg;
         IDX_CFG_LO: chip_rd = cfg_lo_reg;
         IDX_CFG_HI: chip_rd = cfg_hi_reg;
         IDX_CLK_MASK: chip_rd = mask_reg;
         IDX_TEST1: chip_rd = t1_reg;
         IDX_TEST2: chip_rd = t2_reg;
         IDX_TEST3: chip_rd = t3_reg;
         default: chip_rd = RST_ZERO;
      endcase
   end
   wire [7:0] data_rd = in_bank ? (ldn_ok ? bank_rd[sel] : RST_ZERO) : chip_rd;
   // reads have no side effect; zero outside configuration state
   assign bus.rdata = !bus.cfg_mode ? RST_ZERO : hit_index ? index_reg :
                      hit_data ? data_rd : RST_ZERO;
   // gating is a plain AND; real silicon would use a glitch-free gate
   assign clk_out = clk_in & ~mask_reg[NUM_CLKS-1:0];
   assign clk_oe = ~mask_reg[NUM_CLKS-1:0];
   assign irq_edge_high = 1'b1;
endmodule : csr_device

// *** include/csr_pkg.sv ***
package csr_pkg;
   // chip-level indices
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_POWER = 8'h22;
   localparam logic [7:0] IDX_CFG_LO = 8'h26;
   localparam logic [7:0] IDX_CFG_HI = 8'h27;
   localparam logic [7:0] IDX_CLK_MASK = 8'h28;
   localparam logic [7:0] IDX_TEST1 = 8'h2D;
   localparam logic [7:0] IDX_TEST2 = 8'h2E;
   localparam logic [7:0] IDX_TEST3 = 8'h2F;
   localparam logic [7:0] IDX_BANK_LO = 8'h30;
   // per-unit indices
   localparam logic [7:0] IDX_ACT = 8'h30;
   localparam logic [7:0] IDX_PBASE_HI = 8'h60;
   localparam logic [7:0] IDX_PBASE_LO = 8'h61;
   localparam logic [7:0] IDX_SBASE_HI = 8'h62;
   localparam logic [7:0] IDX_SBASE_LO = 8'h63;
   localparam logic [7:0] IDX_IRQ_A = 8'h70;
   localparam logic [7:0] IDX_IRQ_B = 8'h72;
   localparam logic [7:0] IDX_DMA = 8'h74;
   // reset values, masks and sizes
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DMA = 8'h04;
   localparam logic [7:0] RST_CFG_HI = 8'h03;
   localparam logic [7:0] RST_CFG_LO_S0 = 8'hF0;
   localparam logic [7:0] RST_CFG_LO_S1 = 8'h70;
   localparam logic [7:0] CLK_MASK_BITS = 8'h1F;
   localparam logic [7:0] ACT_BITS = 8'h01;
   localparam int NUM_UNITS = 9;
   localparam int NUM_CLKS = 5;
   // unit numbers
   localparam logic [3:0] U_FDC = 4'h0;
   localparam logic [3:0] U_IDE1 = 4'h1;
   localparam logic [3:0] U_IDE2 = 4'h2;
   localparam logic [3:0] U_PAR = 4'h3;
   localparam logic [3:0] U_SER1 = 4'h4;
   localparam logic [3:0] U_SER2 = 4'h5;
   localparam logic [3:0] U_RTC = 4'h6;
   localparam logic [3:0] U_KBD = 4'h7;
   localparam logic [3:0] U_AUX = 4'h8;
   // host register map over axi4-lite
   localparam logic [3:0] HR_CTRL = 4'h0;
   localparam logic [3:0] HR_STAT = 4'h4;
   localparam logic [3:0] HR_RDATA = 4'h8;
   localparam logic [3:0] HR_PORT = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : csr_pkg

// *** include/csr_if.sv ***
`timescale 1ns/10ps
interface csr_if;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic cfg_mode;
   modport dev (input addr, input wdata, input wr, input rd, input cfg_mode, output rdata);
   modport host (output addr, output wdata, output wr, output rd, output cfg_mode, input rdata);
endinterface : csr_if

// *** hdl/csr_unit_bank.sv ***
`timescale 1ns/10ps
module csr_unit_bank
   import csr_pkg::*;
#(
   parameter logic [3:0] UNIT = 4'h0
) (
   // clock
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // access
   input wire logic wr_en,
   input wire logic [7:0] idx,
   input wire logic [7:0] wdata,
   input wire logic pwr_set,
   input wire logic pwr_val,
   output logic [7:0] rdata,
   output logic active,
   output logic [15:0] pbase,
   output logic [15:0] sbase,
   output logic [7:0] irq_a,
   output logic [7:0] irq_b,
   output logic [7:0] dma
);
   localparam logic HAS_SBASE = (UNIT == U_IDE1) || (UNIT == U_IDE2) || (UNIT == U_RTC);
   localparam logic HAS_PBASE = (UNIT != U_RTC) && (UNIT != U_KBD);
   localparam logic HAS_IRQB = (UNIT == U_KBD);
   localparam logic HAS_DMA = (UNIT == U_FDC) || (UNIT == U_SER2) || (UNIT == U_PAR);
   logic [7:0] act_reg, ph_reg, pl_reg, sh_reg, sl_reg, ia_reg, ib_reg, dm_reg;
   wire w_act = wr_en && idx == IDX_ACT;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_reg <= RST_ZERO;
         ph_reg <= RST_ZERO;
         pl_reg <= RST_ZERO;
         sh_reg <= RST_ZERO;
         sl_reg <= RST_ZERO;
         ia_reg <= RST_ZERO;
         ib_reg <= RST_ZERO;
         dm_reg <= RST_DMA;
      end else if (ce) begin
         if (w_act) act_reg <= wdata & ACT_BITS;
         else if (pwr_set) act_reg <= {7'b0, pwr_val};
         if (wr_en && HAS_PBASE && idx == IDX_PBASE_HI) ph_reg <= wdata;
         if (wr_en && HAS_PBASE && idx == IDX_PBASE_LO) pl_reg <= wdata;
         if (wr_en && HAS_SBASE && idx == IDX_SBASE_HI) sh_reg <= wdata;
         if (wr_en && HAS_SBASE && idx == IDX_SBASE_LO) sl_reg <= wdata;
         if (wr_en && idx == IDX_IRQ_A) ia_reg <= wdata;
         if (wr_en && HAS_IRQB && idx == IDX_IRQ_B) ib_reg <= wdata;
         if (wr_en && HAS_DMA && idx == IDX_DMA) dm_reg <= wdata;
      end
   end
   // unused locations read zero
   assign rdata = (idx == IDX_ACT) ? act_reg :
                  (idx == IDX_PBASE_HI) ? ph_reg :
                  (idx == IDX_PBASE_LO) ? pl_reg :
                  (idx == IDX_SBASE_HI) ? sh_reg :
                  (idx == IDX_SBASE_LO) ? sl_reg :
                  (idx == IDX_IRQ_A) ? ia_reg :
                  (idx == IDX_IRQ_B) ? ib_reg :
                  (idx == IDX_DMA && HAS_DMA) ? dm_reg : RST_ZERO;
   assign active = act_reg[0];
   assign pbase = {ph_reg, pl_reg};
   assign sbase = {sh_reg, sl_reg};
   assign irq_a = ia_reg;
   assign irq_b = ib_reg;
   assign dma = dm_reg;
endmodule : csr_unit_bank

// *** hdl/csr_host.sv ***
`timescale 1ns/10ps
module csr_host
   import csr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [3:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [3:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // device side
   csr_if.host dev
);
   import csr_pkg::*;
   logic [15:0] port_reg;
   logic cfg_reg, aw_reg, w_reg;
   logic [3:0] awa_reg;
   logic [31:0] wd_reg;
   logic [7:0] rd_reg;
   logic wr_p_reg, rd_p_reg;
   logic [7:0] op_addr_reg;
   assign s_awready = !aw_reg && !s_bvalid;
   assign s_wready = !w_reg && !s_bvalid;
   assign s_arready = !s_rvalid;
   wire do_wr = aw_reg && w_reg && !s_bvalid;
   // ctrl: [7:0] data, [8] index(0)/data(1), [9] write, [10] read, [16] cfg state
   wire ctrl_hit = awa_reg == HR_CTRL;
   wire port_hit = awa_reg == HR_PORT;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_reg <= {RST_CFG_HI, RST_CFG_LO_S0};
         cfg_reg <= 1'b0;
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awa_reg <= 4'h0;
         wd_reg <= 32'h0000_0000;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
         rd_reg <= RST_ZERO;
         wr_p_reg <= 1'b0;
         rd_p_reg <= 1'b0;
         op_addr_reg <= RST_ZERO;
      end else if (ce) begin
         wr_p_reg <= 1'b0;
         rd_p_reg <= 1'b0;
         if (s_awvalid && s_awready) begin
            aw_reg <= 1'b1;
            awa_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_reg <= 1'b1;
            wd_reg <= s_wdata;
         end
         if (do_wr) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (ctrl_hit || port_hit) ? RESP_OKAY : RESP_SLVERR;
            if (ctrl_hit) begin
               cfg_reg <= wd_reg[16];
               op_addr_reg <= {7'b0, wd_reg[8]};
               wr_p_reg <= wd_reg[9];
               rd_p_reg <= wd_reg[10];
            end
            if (port_hit) port_reg <= {wd_reg[15:1], 1'b0};
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
         if (rd_p_reg) rd_reg <= dev.rdata;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            case (s_araddr)
               HR_CTRL: s_rdata <= {15'h0000, cfg_reg, 16'h0000};
               HR_STAT: s_rdata <= {31'h0000_0000, cfg_reg};
               HR_RDATA: s_rdata <= {24'h00_0000, rd_reg};
               HR_PORT: s_rdata <= {16'h0000, port_reg};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end
   assign dev.addr = port_reg + {15'h0000, op_addr_reg[0]};
   assign dev.wdata = wd_reg[7:0];
   assign dev.wr = wr_p_reg;
   assign dev.rd = rd_p_reg;
   assign dev.cfg_mode = cfg_reg;
endmodule : csr_host

// *** tb/csr_chk.sv ***
`timescale 1ns/10ps
module csr_chk
   import csr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic strap_alt,
   // carrier
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic cfg_mode
);
   logic [15:0] port_reg;
   logic [7:0] lo_reg;
   logic [7:0] idx_reg;
   logic [7:0] ldn_reg;
   logic [7:0] mask_reg;
   // shadow assumes addr bit 0 picks the data port
   wire hit = cfg_mode && (addr[15:1] == port_reg[15:1]);
   wire wr_dat = wr && hit && addr[0];
   wire rd_dat = rd && hit && addr[0];
   wire unimpl = idx_reg inside {[8'h29:8'h2C], [8'h31:8'h5F], 8'h71, 8'h73, [8'h75:8'hDF]};
   wire dma_unit = ldn_reg inside {8'h00, 8'h03, 8'h05};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_reg <= strap_alt ? 16'h0370 : 16'h03F0;
         lo_reg <= strap_alt ? 8'h70 : 8'hF0;
         idx_reg <= 8'h00;
         ldn_reg <= 8'h00;
         mask_reg <= 8'h00;
      end else begin
         if (wr && hit && !addr[0]) idx_reg <= wdata;
         if (wr_dat && idx_reg == IDX_LDN) ldn_reg <= wdata;
         if (wr_dat && idx_reg == IDX_CLK_MASK) mask_reg <= wdata & CLK_MASK_BITS;
         if (wr_dat && idx_reg == IDX_CFG_LO) lo_reg <= wdata;
         if (wr_dat && idx_reg == IDX_CFG_HI) port_reg <= {wdata, lo_reg};
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_wr_one_cycle: assert property (wr |=> !wr)
      else $error("write strobe held past one cycle");
   a_rd_wr_apart: assert property (!(wr && rd))
      else $error("read and write strobes together");
   a_mask_readback: assert property (rd_dat && idx_reg == IDX_CLK_MASK |-> rdata == mask_reg)
      else $error("clock mask readback wrong");
   a_hole_zero: assert property (rd_dat && unimpl |-> rdata == 8'h00)
      else $error("unimplemented location not zero");
   a_act_upper: assert property (rd_dat && idx_reg == IDX_ACT |-> rdata[7:1] == 7'h00)
      else $error("activation upper bits not zero");
   a_irq_b_gate: assert property (rd_dat && idx_reg == IDX_IRQ_B && ldn_reg != 8'h07 |-> rdata == 8'h00)
      else $error("second interrupt select present");
   a_dma_gate: assert property (rd_dat && idx_reg == IDX_DMA && !dma_unit |-> rdata == 8'h00)
      else $error("dma select present on wrong unit");
   a_port_high: assert property (rd_dat && idx_reg == IDX_CFG_HI |-> rdata == port_reg[15:8])
      else $error("port high byte wrong");
   c_mask: cover property (rd_dat && idx_reg == IDX_CLK_MASK);
   c_move: cover property (wr_dat && idx_reg == IDX_CFG_HI);
   c_dma: cover property (rd_dat && idx_reg == IDX_DMA && ldn_reg == 8'h05);
endmodule : csr_chk

// *** tb/tb_config_space_logical_device_regs.sv ***
`timescale 1ns/10ps
module tb_config_space_logical_device_regs;
   import csr_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic soft_reset = 1'h0;
   logic strap_alt = 1'h0;
   logic [4:0] clk_in = 5'h00;
   logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
   logic [31:0] s_wdata = 32'h0;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq_edge_high;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   logic [4:0] clk_out, clk_oe;
   logic [8:0] unit_on, unit_valid;
   logic [33:0] exp_q[$];
   logic [7:0] holes[8] = '{8'h29, 8'h2C, 8'h31, 8'h5F, 8'h71, 8'h73, 8'h75, 8'hDF};
   int fail_count = 0, total_checks = 0, cyc = 0, seed = 32'haedf;
   logic cfg = 1'h1;
   logic [7:0] m;
   csr_if csr_bus();
   csr_device csr_device_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .soft_reset(soft_reset),
      .strap_alt(strap_alt), .bus(csr_bus), .clk_in(clk_in), .clk_out(clk_out), .clk_oe(clk_oe),
      .unit_on(unit_on), .unit_valid(unit_valid), .irq_edge_high(irq_edge_high));
   csr_host csr_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .dev(csr_bus));
   csr_chk csr_chk_inst (.aclk(aclk), .aresetn(aresetn), .strap_alt(strap_alt),
      .addr(csr_bus.addr), .wdata(csr_bus.wdata), .rdata(csr_bus.rdata), .wr(csr_bus.wr),
      .rd(csr_bus.rd), .cfg_mode(csr_bus.cfg_mode));
   initial forever #2 aclk = ~aclk;
   task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      logic ta, tw;
      @(posedge aclk);
      exp_q.push_back({RESP_OKAY, 32'h0});
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hF;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      ta = 1'h0;
      tw = 1'h0;
      while (!(ta && tw)) begin
         @(posedge aclk);
         ta = ta | (s_awready === 1'h1);
         tw = tw | (s_wready === 1'h1);
         if (ta) s_awvalid <= 1'h0;
         if (tw) s_wvalid <= 1'h0;
      end
      while (s_bvalid !== 1'h1) @(posedge aclk);
      s_bready <= 1'h0;
   endtask : axw
   task automatic axr(input logic [3:0] a, input logic [33:0] e);
      @(posedge aclk);
      exp_q.push_back(e);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do @(posedge aclk); while (s_arready !== 1'h1);
      s_arvalid <= 1'h0;
      while (s_rvalid !== 1'h1) @(posedge aclk);
      s_rready <= 1'h0;
   endtask : axr
   // index port write, then data port write or read
   task automatic cw(input logic [7:0] i, input logic [7:0] v);
      axw(HR_CTRL, {15'h0, cfg, 8'h02, i});
      axw(HR_CTRL, {15'h0, cfg, 8'h03, v});
   endtask : cw
   task automatic cr(input logic [7:0] i, input logic [7:0] e);
      axw(HR_CTRL, {15'h0, cfg, 8'h02, i});
      axw(HR_CTRL, {15'h0, cfg, 8'h05, 8'h00});
      repeat (2) @(posedge aclk);
      axr(HR_RDATA, {RESP_OKAY, 24'h0, e});
   endtask : cr
   task automatic hard_reset(input logic s);
      strap_alt <= s;
      aresetn <= 1'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      axw(HR_PORT, s ? 32'h0370 : 32'h03F0);
   endtask : hard_reset
   always @(posedge aclk) begin
      if (s_bvalid && s_bready) chk("bresp", {s_bresp, 32'h0}, exp_q.pop_front());
      if (s_rvalid && s_rready) chk("rdata", {s_rresp, s_rdata}, exp_q.pop_front());
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      hard_reset(1'h0);
      cr(IDX_CLK_MASK, 8'h00);
      cr(IDX_TEST3, 8'h00);
      cr(IDX_ACT, 8'h00);
      cr(IDX_PBASE_HI, 8'h00);
      cr(IDX_PBASE_LO, 8'h00);
      cr(IDX_IRQ_A, 8'h00);
      cr(IDX_DMA, RST_DMA);
      chk("irq_edge_high", irq_edge_high, 1'h1);
      chk("unit_on", unit_on, 9'h000);
      axr(HR_STAT, {RESP_OKAY, 32'h1});
      axr(4'h6, {RESP_SLVERR, 32'h0});
      $display("test reset values done");
      cw(IDX_CLK_MASK, 8'hFF);
      cr(IDX_CLK_MASK, 8'h1F);
      m = $random(seed);
      clk_in <= $random(seed);
      cw(IDX_CLK_MASK, m);
      cr(IDX_CLK_MASK, m & CLK_MASK_BITS);
      chk("clk_oe", clk_oe, {~m[4:0]});
      chk("clk_out", clk_out, {clk_in & ~m[4:0]});
      foreach (holes[k]) begin
         cw(holes[k], 8'hA5);
         cr(holes[k], 8'h00);
      end
      $display("test mask and holes done");
      for (int u = 0; u < 9; u++) begin
         cw(IDX_LDN, u[7:0]);
         cw(IDX_IRQ_A, 8'h10 + u[7:0]);
         cw(IDX_IRQ_B, 8'h5A);
         cw(IDX_DMA, 8'h03);
         cw(IDX_SBASE_HI, 8'h0E);
      end
      for (int u = 0; u < 9; u++) begin
         cw(IDX_LDN, u[7:0]);
         cr(IDX_IRQ_A, 8'h10 + u[7:0]);
         cr(IDX_IRQ_B, (u == 7) ? 8'h5A : 8'h00);
         cr(IDX_DMA, (u inside {0, 3, 5}) ? 8'h03 : 8'h00);
         if (u < 3) cr(IDX_SBASE_HI, (u > 0) ? 8'h0E : 8'h00);
      end
      $display("test banks done");
      cw(IDX_LDN, 8'h03);
      cw(IDX_PBASE_HI, 8'h03);
      cw(IDX_PBASE_LO, 8'h78);
      cw(IDX_ACT, 8'hFF);
      cr(IDX_ACT, 8'h01);
      cr(IDX_POWER, 8'h08);
      chk("unit_on", unit_on, 9'h008);
      chk("unit_valid", unit_valid, 9'h008);
      cw(IDX_PBASE_HI, 8'h00);
      repeat (3) @(posedge aclk);
      chk("unit_valid", unit_valid, 9'h000);
      cw(IDX_POWER, 8'h00);
      cr(IDX_ACT, 8'h00);
      chk("unit_on", unit_on, 9'h000);
      cfg = 1'h0;
      cw(IDX_CLK_MASK, 8'h00);
      cw(IDX_DMA, 8'h01);
      cfg = 1'h1;
      cr(IDX_CLK_MASK, m & CLK_MASK_BITS);
      cr(IDX_DMA, 8'h03);
      $display("test activation and gate done");
      cw(IDX_CFG_LO, 8'h2E);
      cr(IDX_CFG_HI, RST_CFG_HI);
      cw(IDX_CFG_HI, 8'h01);
      cw(IDX_CLK_MASK, 8'h00);
      axw(HR_PORT, 32'h012E);
      axr(HR_PORT, {RESP_OKAY, 32'h0000_012E});
      cr(IDX_CLK_MASK, m & CLK_MASK_BITS);
      cr(IDX_CFG_LO, 8'h2E);
      @(posedge aclk);
      soft_reset <= 1'h1;
      repeat (2) @(posedge aclk);
      soft_reset <= 1'h0;
      cr(IDX_CFG_HI, 8'h01);
      hard_reset(1'h1);
      cr(IDX_CFG_LO, RST_CFG_LO_S1);
      cr(IDX_CFG_HI, RST_CFG_HI);
      $display("test relocation and resets done");
      tally_and_finish();
   end
endmodule : tb_config_space_logical_device_regs
